// >>> verilog/coal_pkg.sv
// Constants shared by the operand address and low-power block.
// Assumes one CPU clock domain with synchronous active-low reset.
package coal_pkg;
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [7:0] DIR_PAGE_HI = 8'h00;
	localparam logic [15:0] INC_ONE = 16'h0001;
	// Operand addressing modes handled here
	typedef enum logic [3:0] {
		COAL_M_IX1 = 4'h0,
		COAL_M_IX1P = 4'h1,
		COAL_M_IX2 = 4'h2,
		COAL_M_SP1 = 4'h3,
		COAL_M_SP2 = 4'h4,
		COAL_M_DD = 4'h5,
		COAL_M_ID = 4'h6,
		COAL_M_XD = 4'h7,
		COAL_M_DX = 4'h8
	} coal_mode_t;
	// Power states of the core
	typedef enum logic [1:0] {
		COAL_P_RUN = 2'h0,
		COAL_P_WAIT = 2'h1,
		COAL_P_STOP = 2'h2,
		COAL_P_BKG = 2'h3
	} coal_pwr_t;
	// Debug commands seen by this block
	typedef enum logic [1:0] {
		COAL_C_HALT = 2'h0,
		COAL_C_MEMST = 2'h1,
		COAL_C_OTHER = 2'h2
	} coal_cmd_t;
	localparam logic [1:0] ST_OK = 2'h0;
	localparam logic [1:0] ST_LOWPWR = 2'h1;
	localparam logic [1:0] ST_REFUSED = 2'h2;
	// Extra cycle taken by stack-relative forms (pre-byte)
	localparam logic [2:0] SP_EXTRA_CYC = 3'h1;
endpackage

// >>> verilog/coal_ea_if.sv
// Carrier between the top and the address adder.
// Assumes all members change on the CPU clock.
`timescale 1ns/1ps
`default_nettype none
interface coal_ea_if;
	logic [15:0] base;
	logic [15:0] offset;
	logic [15:0] sum;
	modport top (output base, output offset, input sum);
	modport adder (input base, input offset, output sum);
endinterface
`default_nettype wire

// >>> verilog/coal_ea_add.sv
// Combinational 16-bit effective address adder.
// Assumes base and offset settle within one CPU clock.
`timescale 1ns/1ps
`default_nettype none
module coal_ea_add (
	coal_ea_if.adder ea
);
	import coal_pkg::*;
	// Carry out dropped on purpose: addresses wrap
	assign ea.sum = ea.base + ea.offset;
endmodule
`default_nettype wire

// >>> verilog/coal_core.sv
// Operand address generation and stop/wait control of an 8-bit core.
// Assumes an instruction sequencer supplies mode and operand bytes,
// and a debug serial front end supplies decoded command pulses.
// Contract
// - Index byte offset: pair plus byte
// - Byte offset postinc: access, then bump pair
// - Word offset: high byte first, add pair
// - Stack byte offset: stack pointer plus byte
// - Stack forms take one extra cycle
// - Stack word offset: stack pointer plus word
// - Direct move: first byte source, second dest
// - Immediate move: first byte data, second dest
// - Indexed to direct: bump after read
// - Direct to indexed: bump after write
// - Optional clocks kept for periodic stop wakeup
// - Debug enabled keeps oscillator on in stop
// - Halt command in stop enters background (here only with debug enabled)
// - Wait clears mask, then halts clocks (here both in the same cycle)
// - Interrupt or reset wakes from wait
// - Halt command in wait enters background
// - Only halt and status commands in wait
// - Status command in low power: error only
// - Direct page high byte is zero
// - Addresses 16 bits, no extra cycles
`timescale 1ns/1ps
`default_nettype none
module coal_core #(
	parameter int BASE_CYC_MAX = 6
) (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Address request from the sequencer
	input wire logic ea_req_in,
	input wire coal_pkg::coal_mode_t mode_in,
	input wire logic [7:0] op_byte1_in,
	input wire logic [7:0] op_byte2_in,
	input wire logic [2:0] base_cycles_in,
	input wire logic [15:0] stack_pointer_reg_in,
	// Move phase markers from the sequencer
	input wire logic src_done_in,
	input wire logic dst_done_in,
	// Index pair load
	input wire logic hx_load_in,
	input wire logic [15:0] hx_load_val_in,
	// Address results
	output logic ea_valid_out,
	output logic [15:0] ea_src_out,
	output logic [15:0] ea_dst_out,
	output logic [7:0] imm_data_out,
	output logic imm_src_out,
	output logic [2:0] exec_cycles_out,
	output logic [15:0] index_pair_out,
	// Low power control
	input wire logic wait_exec_in,
	input wire logic stop_exec_in,
	input wire logic irq_in,
	input wire logic periodic_wake_in,
	input wire logic stop_clk_keep_in,
	input wire logic debug_enable_bit_in,
	output logic int_mask_clr_out,
	output logic cpu_clk_en_out,
	output logic osc_keep_out,
	output logic stop_clk_keep_out,
	output logic bkg_active_out,
	output logic irq_service_out,
	output logic [1:0] pwr_state_out,
	// Debug command from the serial front end
	input wire logic cmd_valid_in,
	input wire coal_pkg::coal_cmd_t cmd_in,
	output logic cmd_resp_valid_out,
	output logic [1:0] cmd_status_out,
	output logic cmd_mem_go_out
);
	import coal_pkg::*;

	// Base count plus the stack extra cycle must fit three bits
	if (BASE_CYC_MAX < 1 || BASE_CYC_MAX > 6) begin : g_bad_cyc
		$error("BASE_CYC_MAX must be 1..6");
	end

	coal_ea_if ea_a ();
	coal_ea_if ea_b ();
	coal_ea_add u_add_a (.ea(ea_a.adder));
	coal_ea_add u_add_b (.ea(ea_b.adder));

	logic [15:0] hx_r;
	logic [15:0] dir1;
	logic [15:0] dir2;
	logic [15:0] word_off;
	logic inc_pend_r;
	logic inc_fire;
	coal_pwr_t pwr_r;
	coal_pwr_t pwr_nxt;
	logic lowpwr;
	logic [15:0] src_nxt;
	logic [15:0] dst_nxt;
	logic imm_nxt;

	// Direct page addresses always land in 0000..00FF
	assign dir1 = {DIR_PAGE_HI, op_byte1_in};
	assign dir2 = {DIR_PAGE_HI, op_byte2_in};
	// First byte after opcode is the high half
	assign word_off = {op_byte1_in, op_byte2_in};
	assign lowpwr = (pwr_r == COAL_P_WAIT) || (pwr_r == COAL_P_STOP);
	// Only the access the mode names spends the bump; the read
	// phase of a direct-to-indexed move must leave it pending
	assign inc_fire = inc_pend_r && (((mode_in == COAL_M_IX1P ||
		mode_in == COAL_M_XD) && src_done_in) ||
		(mode_in == COAL_M_DX && dst_done_in));

	// Adder operand selection
	always_comb begin
		ea_a.base = hx_r;
		ea_a.offset = {8'h00, op_byte1_in};
		ea_b.base = stack_pointer_reg_in;
		ea_b.offset = {8'h00, op_byte1_in};
		case (mode_in)
			COAL_M_IX2: begin
				ea_a.offset = word_off;
			end
			COAL_M_SP2: begin
				ea_b.offset = word_off;
			end
			default: begin
			end
		endcase
	end

	// Source and destination per mode
	always_comb begin
		src_nxt = 16'h0000;
		dst_nxt = 16'h0000;
		imm_nxt = 1'b0;
		case (mode_in)
			COAL_M_IX1: src_nxt = ea_a.sum;
			COAL_M_IX1P: src_nxt = ea_a.sum;
			COAL_M_IX2: src_nxt = ea_a.sum;
			COAL_M_SP1: src_nxt = ea_b.sum;
			COAL_M_SP2: src_nxt = ea_b.sum;
			COAL_M_DD: begin
				src_nxt = dir1;
				dst_nxt = dir2;
			end
			COAL_M_ID: begin
				imm_nxt = 1'b1;
				dst_nxt = dir2;
			end
			COAL_M_XD: begin
				src_nxt = hx_r;
				dst_nxt = dir1;
			end
			COAL_M_DX: begin
				src_nxt = dir1;
				dst_nxt = hx_r;
			end
			default: begin
			end
		endcase
	end

	// Address results, registered one cycle after request
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			ea_valid_out <= 1'b0;
			ea_src_out <= 16'h0000;
			ea_dst_out <= 16'h0000;
			imm_data_out <= 8'h00;
			imm_src_out <= 1'b0;
			exec_cycles_out <= 3'h0;
		end else begin
			ea_valid_out <= ea_req_in;
			if (ea_req_in) begin
				ea_src_out <= src_nxt;
				ea_dst_out <= dst_nxt;
				imm_data_out <= op_byte1_in;
				imm_src_out <= imm_nxt;
				// Pre-byte costs a cycle; addressing itself adds none
				if (mode_in == COAL_M_SP1 || mode_in == COAL_M_SP2)
					exec_cycles_out <= base_cycles_in + SP_EXTRA_CYC;
				else
					exec_cycles_out <= base_cycles_in;
			end
		end
	end

	// Pending increment waits for the operand access
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			inc_pend_r <= 1'b0;
		end else if (ea_req_in) begin
			inc_pend_r <= (mode_in == COAL_M_IX1P) ||
				(mode_in == COAL_M_XD) || (mode_in == COAL_M_DX);
		end else if (inc_fire) begin
			inc_pend_r <= 1'b0;
		end
	end

	// Index pair; bump after read or write as the mode says
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			hx_r <= 16'h0000;
		end else if (hx_load_in) begin
			hx_r <= hx_load_val_in;
		end else if (inc_pend_r) begin
			if ((mode_in == COAL_M_IX1P || mode_in == COAL_M_XD)
				&& src_done_in)
				hx_r <= hx_r + INC_ONE;
			else if (mode_in == COAL_M_DX && dst_done_in)
				hx_r <= hx_r + INC_ONE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			index_pair_out <= 16'h0000;
		else
			index_pair_out <= hx_r;
	end

	// Power state transitions
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			COAL_P_RUN: begin
				if (wait_exec_in)
					pwr_nxt = COAL_P_WAIT;
				else if (stop_exec_in)
					pwr_nxt = COAL_P_STOP;
			end
			COAL_P_WAIT: begin
				if (cmd_valid_in && cmd_in == COAL_C_HALT)
					pwr_nxt = COAL_P_BKG;
				else if (irq_in)
					pwr_nxt = COAL_P_RUN;
			end
			COAL_P_STOP: begin
				if (debug_enable_bit_in && cmd_valid_in &&
					cmd_in == COAL_C_HALT)
					pwr_nxt = COAL_P_BKG;
				else if (irq_in || (stop_clk_keep_in && periodic_wake_in))
					pwr_nxt = COAL_P_RUN;
			end
			COAL_P_BKG: begin
			end
			default: pwr_nxt = COAL_P_RUN;
		endcase
	end

	// Reset also wakes from wait by this synchronous reset
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			pwr_r <= COAL_P_RUN;
		else
			pwr_r <= pwr_nxt;
	end

	// Mask cleared in the same cycle clocks stop
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			int_mask_clr_out <= 1'b0;
		else
			int_mask_clr_out <= (pwr_r == COAL_P_RUN) &&
				wait_exec_in;
	end

	// Clock gate request; high means the core clock runs
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			cpu_clk_en_out <= 1'b1;
		else
			cpu_clk_en_out <= !(pwr_nxt == COAL_P_WAIT ||
				pwr_nxt == COAL_P_STOP);
	end

	// Oscillator held in stop only while a debugger may call
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			osc_keep_out <= 1'b0;
		else
			osc_keep_out <= (pwr_nxt == COAL_P_STOP) &&
				debug_enable_bit_in;
	end

	// Minimal clocks kept so the periodic wake can still arrive
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			stop_clk_keep_out <= 1'b0;
		else
			stop_clk_keep_out <= (pwr_nxt == COAL_P_STOP) &&
				stop_clk_keep_in;
	end

	// Background sticks until reset
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			bkg_active_out <= 1'b0;
		else
			bkg_active_out <= (pwr_nxt == COAL_P_BKG);
	end

	// Woken interrupt goes down the normal path
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			irq_service_out <= 1'b0;
		else
			irq_service_out <= lowpwr && irq_in &&
				(pwr_nxt == COAL_P_RUN);
	end

	// Visible copy of the power state
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in)
			pwr_state_out <= COAL_P_RUN;
		else
			pwr_state_out <= pwr_nxt;
	end

	// Debug command answers; low power forbids memory access
	always_ff @(posedge sys_clk_in) begin
		if (!reset_n_in) begin
			cmd_resp_valid_out <= 1'b0;
			cmd_status_out <= ST_OK;
			cmd_mem_go_out <= 1'b0;
		end else begin
			cmd_resp_valid_out <= cmd_valid_in;
			cmd_mem_go_out <= 1'b0;
			if (cmd_valid_in) begin
				if (lowpwr && cmd_in == COAL_C_MEMST) begin
					cmd_status_out <= ST_LOWPWR;
				end else if (lowpwr && cmd_in == COAL_C_OTHER) begin
					cmd_status_out <= ST_REFUSED;
				end else if (pwr_r == COAL_P_STOP &&
					!debug_enable_bit_in) begin
					cmd_status_out <= ST_REFUSED;
				end else begin
					cmd_status_out <= ST_OK;
					cmd_mem_go_out <= (cmd_in != COAL_C_HALT);
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/coal_chk.sv
// Port-level checks for the operand address and low-power core.
// Assumes one clock and a synchronous active-low reset; bound below.
`timescale 1ns/1ps
`default_nettype none
module coal_chk
	import coal_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// Watched inputs
	input wire logic ea_req_in,
	input wire coal_pkg::coal_mode_t mode_in,
	input wire logic [7:0] op_byte1_in,
	input wire logic [7:0] op_byte2_in,
	input wire logic [2:0] base_cycles_in,
	input wire logic [15:0] stack_pointer_reg_in,
	input wire logic wait_exec_in,
	input wire logic irq_in,
	input wire logic cmd_valid_in,
	input wire coal_pkg::coal_cmd_t cmd_in,
	// Watched outputs
	input wire logic ea_valid_out,
	input wire logic [15:0] ea_src_out,
	input wire logic [15:0] ea_dst_out,
	input wire logic [2:0] exec_cycles_out,
	input wire logic int_mask_clr_out,
	input wire logic cpu_clk_en_out,
	input wire logic [1:0] pwr_state_out,
	input wire logic cmd_resp_valid_out,
	input wire logic [1:0] cmd_status_out,
	input wire logic cmd_mem_go_out
);
	default clocking dc @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Answers to a wake or a refused access land one cycle on
	sequence s_woken;
		cpu_clk_en_out && pwr_state_out == COAL_P_RUN;
	endsequence
	sequence s_lowpwr_err;
		cmd_resp_valid_out && cmd_status_out == ST_LOWPWR && !cmd_mem_go_out;
	endsequence
	a_ea_valid_next: assert property (
		ea_req_in |=> ea_valid_out) else $error("address answer late");
	a_dir_page_hi: assert property (
		ea_req_in && mode_in == COAL_M_DD |=>
		ea_src_out == {8'h00, $past(op_byte1_in)} &&
		ea_dst_out == {8'h00, $past(op_byte2_in)})
		else $error("direct page address wrong");
	a_stack_byte_sum: assert property (
		ea_req_in && mode_in == COAL_M_SP1 |=> ea_src_out ==
		$past(stack_pointer_reg_in) + {8'h00, $past(op_byte1_in)})
		else $error("stack byte sum wrong");
	a_stack_extra_cyc: assert property (
		ea_req_in && (mode_in == COAL_M_SP1 || mode_in == COAL_M_SP2) |=>
		exec_cycles_out == $past(base_cycles_in) + 3'h1)
		else $error("stack form cycle count wrong");
	a_wait_mask_clr: assert property (
		pwr_state_out == COAL_P_RUN && wait_exec_in |=> int_mask_clr_out &&
		!cpu_clk_en_out && pwr_state_out == COAL_P_WAIT)
		else $error("wait entry wrong");
	a_irq_wakes: assert property (
		pwr_state_out == COAL_P_WAIT && irq_in && !cmd_valid_in |=> s_woken)
		else $error("interrupt did not wake");
	a_memst_error: assert property (
		pwr_state_out == COAL_P_WAIT && cmd_valid_in &&
		cmd_in == COAL_C_MEMST |=> s_lowpwr_err)
		else $error("status access not refused");
	a_halt_to_bkg: assert property (
		pwr_state_out == COAL_P_WAIT && cmd_valid_in && cmd_in == COAL_C_HALT
		|=> cpu_clk_en_out && pwr_state_out == COAL_P_BKG)
		else $error("halt did not enter background");
endmodule
bind coal_core coal_chk u_chk (
	.sys_clk_in(sys_clk_in),
	.reset_n_in(reset_n_in),
	.ea_req_in(ea_req_in),
	.mode_in(mode_in),
	.op_byte1_in(op_byte1_in),
	.op_byte2_in(op_byte2_in),
	.base_cycles_in(base_cycles_in),
	.stack_pointer_reg_in(stack_pointer_reg_in),
	.wait_exec_in(wait_exec_in),
	.irq_in(irq_in),
	.cmd_valid_in(cmd_valid_in),
	.cmd_in(cmd_in),
	.ea_valid_out(ea_valid_out),
	.ea_src_out(ea_src_out),
	.ea_dst_out(ea_dst_out),
	.exec_cycles_out(exec_cycles_out),
	.int_mask_clr_out(int_mask_clr_out),
	.cpu_clk_en_out(cpu_clk_en_out),
	.pwr_state_out(pwr_state_out),
	.cmd_resp_valid_out(cmd_resp_valid_out),
	.cmd_status_out(cmd_status_out),
	.cmd_mem_go_out(cmd_mem_go_out)
);
`default_nettype wire

// >>> tb/coal_host.sv
// Host debug model: sends one decoded serial command at a time.
// Assumes the caller runs between clock edges.
`timescale 1ns/1ps
`default_nettype none
module coal_host
	import coal_pkg::*;
(
	// Clock
	input wire logic sys_clk_in,
	// Command to the core
	output var logic cmd_valid_out,
	output var coal_pkg::coal_cmd_t cmd_out
);
	initial begin
		cmd_valid_out = 1'b0;
		cmd_out = COAL_C_OTHER;
	end
	// Idle lines show the inverse so a stale code never passes
	task automatic send(input coal_cmd_t k);
		@(posedge sys_clk_in);
		#1;
		cmd_valid_out = 1'b1;
		cmd_out = k;
		@(posedge sys_clk_in);
		#1;
		cmd_valid_out = 1'b0;
		cmd_out = coal_cmd_t'(~k);
	endtask
endmodule
`default_nettype wire

// >>> tb/cpu_operand_address_and_low_power_bench.sv
// Self-checking bench for the operand address and low-power core.
// Assumes the package, design, host model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
	$display("mismatch %0t %h %h", $time, (a), (b)); end end
module cpu_operand_address_and_low_power_bench;
	import coal_pkg::*;
	int bad_count = 0, n_checks = 0;
	logic sys_clk_in, reset_n_in = 1'b0, ea_req_in = 1'b0;
	logic src_done_in = 1'b0, dst_done_in = 1'b0, hx_load_in = 1'b0;
	logic wait_exec_in = 1'b0, irq_in = 1'b0, stop_exec_in = 1'b0;
	logic periodic_wake_in = 1'b0, stop_clk_keep_in = 1'b0;
	logic debug_enable_bit_in = 1'b0, cmd_valid_in;
	coal_mode_t mode_in = COAL_M_IX1;
	coal_cmd_t cmd_in;
	logic [7:0] op_byte1_in = 8'h00, op_byte2_in = 8'h00, imm_data_out;
	logic [2:0] base_cycles_in = 3'h3, exec_cycles_out;
	logic [15:0] stack_pointer_reg_in = 16'hFFF0;
	logic [15:0] hx_load_val_in = 16'h0000;
	logic [15:0] ea_src_out, ea_dst_out, index_pair_out;
	logic ea_valid_out, imm_src_out, int_mask_clr_out, cpu_clk_en_out;
	logic osc_keep_out, stop_clk_keep_out, bkg_active_out, irq_service_out;
	logic cmd_resp_valid_out, cmd_mem_go_out;
	logic [1:0] pwr_state_out, cmd_status_out;
	coal_core dut (.*);
	coal_host host (.sys_clk_in, .cmd_valid_out(cmd_valid_in),
		.cmd_out(cmd_in));
	// Inputs move 1 ns after the edge to stay clear of sampling
	task automatic step(int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic rst;
		reset_n_in = 1'b0;
		step(20);
		reset_n_in = 1'b1;
	endtask
	task automatic hx(logic [15:0] v);
		hx_load_in = 1'b1;
		hx_load_val_in = v;
		step(1);
		hx_load_in = 1'b0;
		step(1);
	endtask
	// Bits: 8 wait, 4 stop, 2 interrupt, 1 periodic wake
	task automatic pulse(int k);
		{wait_exec_in, stop_exec_in, irq_in, periodic_wake_in} = 4'(k);
		step(1);
		{wait_exec_in, stop_exec_in, irq_in, periodic_wake_in} = 4'h0;
	endtask
	task automatic bump(bit dst);
		src_done_in = !dst;
		dst_done_in = dst;
		step(1);
		{src_done_in, dst_done_in} = 2'b00;
		step(1);
	endtask
	task automatic ea(coal_mode_t m, logic [7:0] b1, b2, logic [15:0] s, d);
		mode_in = m;
		op_byte1_in = b1;
		op_byte2_in = b2;
		ea_req_in = 1'b1;
		step(1);
		ea_req_in = 1'b0;
		`CHK(ea_valid_out, 1'b1)
		if (m == COAL_M_ID) `CHK({imm_src_out, imm_data_out}, {1'b1, b1})
		else `CHK(ea_src_out, s)
		if (m >= COAL_M_DD) `CHK(ea_dst_out, d)
	endtask
	task automatic t_index;
		hx(16'h1234);
		ea(COAL_M_IX1, 8'hF0, 8'h00, 16'h1324, 16'h0000);
		`CHK(exec_cycles_out, 3'h3)
		ea(COAL_M_IX2, 8'hAB, 8'hCD, 16'hBE01, 16'h0000);
		ea(COAL_M_SP1, 8'h20, 8'h00, 16'h0010, 16'h0000);
		`CHK(exec_cycles_out, 3'h4)
		ea(COAL_M_SP2, 8'h01, 8'h02, 16'h00F2, 16'h0000);
		`CHK(exec_cycles_out, 3'h4)
		$display("test index done");
	endtask
	task automatic t_move;
		ea(COAL_M_DD, 8'h12, 8'h34, 16'h0012, 16'h0034);
		ea(COAL_M_ID, 8'h5A, 8'h77, 16'h0000, 16'h0077);
		hx(16'h0200);
		ea(COAL_M_XD, 8'h40, 8'h00, 16'h0200, 16'h0040);
		bump(1'b0);
		`CHK(index_pair_out, 16'h0201)
		ea(COAL_M_DX, 8'h41, 8'h00, 16'h0041, 16'h0201);
		bump(1'b0);
		`CHK(index_pair_out, 16'h0201)
		bump(1'b1);
		`CHK(index_pair_out, 16'h0202)
		hx(16'hFFFF);
		ea(COAL_M_IX1P, 8'h10, 8'h00, 16'h000F, 16'h0000);
		bump(1'b0);
		`CHK(index_pair_out, 16'h0000)
		$display("test move done");
	endtask
	task automatic t_wait;
		rst;
		pulse(8);
		`CHK({int_mask_clr_out, cpu_clk_en_out, pwr_state_out}, 4'h9)
		pulse(2);
		`CHK({irq_service_out, cpu_clk_en_out, pwr_state_out}, 4'hC)
		pulse(8);
		host.send(COAL_C_OTHER);
		`CHK({cmd_resp_valid_out, cmd_status_out}, {1'b1, ST_REFUSED})
		host.send(COAL_C_MEMST);
		`CHK({cmd_mem_go_out, cmd_status_out}, {1'b0, ST_LOWPWR})
		host.send(COAL_C_HALT);
		`CHK({bkg_active_out, cpu_clk_en_out, pwr_state_out}, 4'hF)
		$display("test wait done");
	endtask
	task automatic t_stop;
		rst;
		stop_clk_keep_in = 1'b1;
		pulse(4);
		`CHK({osc_keep_out, stop_clk_keep_out, pwr_state_out}, 4'h6)
		host.send(COAL_C_HALT);
		`CHK({cmd_status_out, pwr_state_out}, {ST_REFUSED, COAL_P_STOP})
		pulse(1);
		`CHK(pwr_state_out, 2'h0)
		host.send(COAL_C_MEMST);
		`CHK({cmd_mem_go_out, cmd_status_out}, {1'b1, ST_OK})
		debug_enable_bit_in = 1'b1;
		pulse(4);
		`CHK({osc_keep_out, cpu_clk_en_out}, 2'b10)
		host.send(COAL_C_MEMST);
		`CHK(cmd_status_out, ST_LOWPWR)
		host.send(COAL_C_HALT);
		`CHK({cpu_clk_en_out, pwr_state_out}, 3'h7)
		$display("test stop done");
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Free-running clock, 8 ns period
	initial begin
		sys_clk_in = 0;
		forever #4 sys_clk_in = ~sys_clk_in;
	end
	initial begin
		rst;
		t_index;
		t_move;
		t_wait;
		t_stop;
		report_and_stop;
	end
endmodule
`default_nettype wire
